// [include/sfgs_regs.vh]
// register map, field widths, reset values and timing counts of the gain switch block
// assumes a 50 MHz control clock and an apb master with 32-bit data
//
// Summary of operation
// - blend coefficient 0..1000, default 1000
// - speed feedforward select 0/1, restart effective
// - speed feedforward gain 0..1500, default 300
// - speed feedforward filter 0..6400, default 50
// - torque feedforward select 0..2, restart effective
// - torque feedforward gain 0..1000, default 0
// - torque feedforward filter 0..6400, default 0
// - input role picks p/pi or group
// - mode 0 group one, 1 group two
// - mode 2 follows discrete gain input
// - mode 3 torque command with hysteresis
// - mode 4 unused, keeps group one
// - mode 5 speed command with hysteresis
// - mode 6 position deviation with hysteresis
// - mode 7 nonzero position command, with switch delay
// - mode 8 positioning incomplete selects group two
// - mode 9 speed feedback with hysteresis
// - mode 10 command plus low actual speed
// - switch delay 0..1000 in 0.1 ms
// - level 0..20000 default 50, hysteresis 33
// - upward switch ramped over transition time
// - group two mirrors group one contents
`ifndef SFGS_REGS_VH
`define SFGS_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SFGS_OFS_BLEND 12'h000
`define SFGS_OFS_SFF_SEL 12'h004
`define SFGS_OFS_SFF_GAIN 12'h008
`define SFGS_OFS_SFF_FILT 12'h00c
`define SFGS_OFS_TFF_SEL 12'h010
`define SFGS_OFS_TFF_GAIN 12'h014
`define SFGS_OFS_TFF_FILT 12'h018
`define SFGS_OFS_ROLE 12'h01c
`define SFGS_OFS_MODE 12'h020
`define SFGS_OFS_DELAY 12'h024
`define SFGS_OFS_LEVEL 12'h028
`define SFGS_OFS_HYST 12'h02c
`define SFGS_OFS_RAMP 12'h030
`define SFGS_OFS_STATUS 12'h034

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SFGS_RST_BLEND 16'h03e8
`define SFGS_RST_SFF_SEL 16'h0000
`define SFGS_RST_SFF_GAIN 16'h012c
`define SFGS_RST_SFF_FILT 16'h0032
`define SFGS_RST_TFF_SEL 16'h0000
`define SFGS_RST_TFF_GAIN 16'h0000
`define SFGS_RST_TFF_FILT 16'h0000
`define SFGS_RST_ROLE 16'h0000
`define SFGS_RST_MODE 16'h0000
`define SFGS_RST_DELAY 16'h0032
`define SFGS_RST_LEVEL 16'h0032
`define SFGS_RST_HYST 16'h0021
`define SFGS_RST_RAMP 16'h0021

// ----------------------------------------------------------------
// maxima of each setting
// ----------------------------------------------------------------
`define SFGS_MAX_BLEND 16'h03e8
`define SFGS_MAX_SFF_SEL 16'h0001
`define SFGS_MAX_SFF_GAIN 16'h05dc
`define SFGS_MAX_FILT 16'h1900
`define SFGS_MAX_TFF_SEL 16'h0002
`define SFGS_MAX_TFF_GAIN 16'h03e8
`define SFGS_MAX_ROLE 16'h0001
`define SFGS_MAX_MODE 16'h000a
`define SFGS_MAX_DELAY 16'h03e8
`define SFGS_MAX_LEVEL 16'h4e20
`define SFGS_MAX_RAMP 16'h2710

// ----------------------------------------------------------------
// status fields and timing
// ----------------------------------------------------------------
`define SFGS_ST_GROUP 0
`define SFGS_ST_PMODE 1
`define SFGS_ST_RAMP_BUSY 2
// delay and ramp tick is 0.1 ms = 100000 ns
`define SFGS_TICK_NS 100000
`define SFGS_CLK_NS 20
`define SFGS_TICK_CYC (`SFGS_TICK_NS / `SFGS_CLK_NS)

`endif

// [src/sfgs_gain_switch.v]
// gain switch selector with feedforward settings and apb register file
// assumes inputs from the loop side are synchronous to clk_sys_in except the discrete input
`timescale 1ns/1ns
`include "sfgs_regs.vh"

module sfgs_gain_switch #(
   parameter TICK_CYC = `SFGS_TICK_CYC
) (
   input wire clk_sys_in,
   input wire rst_b_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [11:0] paddr_in,
   input wire [31:0] pwdata_in,
   output reg [31:0] prdata_out,
   output reg pready_out,
   output reg pslverr_out,
   input wire discrete_input_in,
   input wire signed [31:0] torque_cmd_in,
   input wire signed [31:0] speed_cmd_in,
   input wire signed [31:0] pos_deviation_in,
   input wire signed [31:0] pos_cmd_in,
   input wire signed [31:0] speed_fb_in,
   input wire positioning_done_in,
   output reg gain_group_out,
   output reg p_only_out,
   output reg [15:0] gain_blend_out,
   output reg ramp_busy_out,
   output reg [15:0] speed_regulator_blend_out,
   output reg speed_ff_select_out,
   output reg [15:0] speed_ff_gain_out,
   output reg [15:0] speed_ff_filter_time_out,
   output reg [1:0] torque_ff_select_out,
   output reg [15:0] torque_ff_gain_out,
   output reg [15:0] torque_ff_filter_time_out
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // clamp a written value to the setting's maximum
   function [15:0] clamp16;
      input [31:0] val;
      input [15:0] max;
      begin
         clamp16 = (val > {16'h0000, max}) ? max : val[15:0];
      end
   endfunction

   // absolute value of a signed sample
   function [31:0] abs32;
      input [31:0] val;
      begin
         abs32 = val[31] ? (~val) + 32'h00000001 : val;
      end
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   reg [15:0] blend_r;        // blend coefficient
   reg [15:0] sff_sel_r;      // written speed ff select
   reg [15:0] sff_gain_r;
   reg [15:0] sff_filt_r;
   reg [15:0] tff_sel_r;      // written torque ff select
   reg [15:0] tff_gain_r;
   reg [15:0] tff_filt_r;
   reg [15:0] role_r;
   reg [15:0] mode_r;
   reg [15:0] delay_r;
   reg [15:0] level_r;
   reg [15:0] hyst_r;
   reg [15:0] ramp_r;
   reg [1:0] boot_r;          // counts the first cycles after reset release
   reg di_meta_r;             // synchroniser first stage
   reg di_sync_r;             // synchronised discrete input
   reg group_r;               // selected gain group, 0 is group one
   reg group_nxt;
   reg [15:0] dly_cnt_r;      // delay counter in 0.1 ms ticks
   reg [15:0] dly_cnt_nxt;
   reg go_up_nxt; // mode asks for group two
   reg go_back_nxt; // return condition of the mode holds
   reg [15:0] tick_r;         // cycle prescaler for 0.1 ms
   reg [15:0] ramp_cnt_r;     // ticks elapsed in upward ramp
   reg [15:0] ramp_cnt_nxt;
   reg ramping_r;
   reg ramping_nxt;
   reg [31:0] rdata_nxt;
   reg rerr_nxt;

   wire tick_w;
   wire wr_w;
   wire rd_w;
   wire [31:0] mag_w;         // monitored magnitude for level modes
   wire [31:0] up_th_w;
   wire [31:0] dn_th_w;
   wire cmd_zero_w;

   assign tick_w = (tick_r == (TICK_CYC[15:0] - 16'h0001));
   assign wr_w = psel_in & penable_in & pwrite_in;
   assign rd_w = psel_in & penable_in & ~pwrite_in;
   assign cmd_zero_w = (pos_cmd_in == 32'sh00000000);

   assign up_th_w = {16'h0000, level_r} + {16'h0000, hyst_r};
   assign dn_th_w = {16'h0000, level_r} - {16'h0000, hyst_r};

   // pick the monitored quantity for the active mode
   assign mag_w = (mode_r == 16'h0003) ? abs32(torque_cmd_in) :
                  (mode_r == 16'h0005) ? abs32(speed_cmd_in) :
                  (mode_r == 16'h0006) ? abs32(pos_deviation_in) :
                  abs32(speed_fb_in);

   // ----------------------------------------------------------------
   // discrete input synchroniser
   // ----------------------------------------------------------------
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         di_meta_r <= 1'b0;
         di_sync_r <= 1'b0;
      end else begin
         di_meta_r <= discrete_input_in;
         di_sync_r <= di_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // apb register writes
   // ----------------------------------------------------------------
   // zero-wait slave: writes land at the access edge
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         blend_r <= `SFGS_RST_BLEND;
         sff_sel_r <= `SFGS_RST_SFF_SEL;
         sff_gain_r <= `SFGS_RST_SFF_GAIN;
         sff_filt_r <= `SFGS_RST_SFF_FILT;
         tff_sel_r <= `SFGS_RST_TFF_SEL;
         tff_gain_r <= `SFGS_RST_TFF_GAIN;
         tff_filt_r <= `SFGS_RST_TFF_FILT;
         role_r <= `SFGS_RST_ROLE;
         mode_r <= `SFGS_RST_MODE;
         delay_r <= `SFGS_RST_DELAY;
         level_r <= `SFGS_RST_LEVEL;
         hyst_r <= `SFGS_RST_HYST;
         ramp_r <= `SFGS_RST_RAMP;
      end else if (wr_w) begin
         case (paddr_in)
            `SFGS_OFS_BLEND: blend_r <= clamp16(pwdata_in, `SFGS_MAX_BLEND);
            `SFGS_OFS_SFF_SEL: sff_sel_r <= clamp16(pwdata_in, `SFGS_MAX_SFF_SEL);
            `SFGS_OFS_SFF_GAIN: sff_gain_r <= clamp16(pwdata_in, `SFGS_MAX_SFF_GAIN);
            `SFGS_OFS_SFF_FILT: sff_filt_r <= clamp16(pwdata_in, `SFGS_MAX_FILT);
            `SFGS_OFS_TFF_SEL: tff_sel_r <= clamp16(pwdata_in, `SFGS_MAX_TFF_SEL);
            `SFGS_OFS_TFF_GAIN: tff_gain_r <= clamp16(pwdata_in, `SFGS_MAX_TFF_GAIN);
            `SFGS_OFS_TFF_FILT: tff_filt_r <= clamp16(pwdata_in, `SFGS_MAX_FILT);
            `SFGS_OFS_ROLE: role_r <= clamp16(pwdata_in, `SFGS_MAX_ROLE);
            `SFGS_OFS_MODE: mode_r <= clamp16(pwdata_in, `SFGS_MAX_MODE);
            `SFGS_OFS_DELAY: delay_r <= clamp16(pwdata_in, `SFGS_MAX_DELAY);
            `SFGS_OFS_LEVEL: begin
               if (clamp16(pwdata_in, `SFGS_MAX_LEVEL) < hyst_r) begin
                  level_r <= hyst_r;
               end else begin
                  level_r <= clamp16(pwdata_in, `SFGS_MAX_LEVEL);
               end
            end
            `SFGS_OFS_HYST: begin
               if (clamp16(pwdata_in, `SFGS_MAX_LEVEL) > level_r) begin
                  hyst_r <= level_r;
               end else begin
                  hyst_r <= clamp16(pwdata_in, `SFGS_MAX_LEVEL);
               end
            end
            `SFGS_OFS_RAMP: ramp_r <= clamp16(pwdata_in, `SFGS_MAX_RAMP);
            default: begin
               // unmapped or read-only: ignored, flagged by pslverr
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // apb read mux
   // ----------------------------------------------------------------
   always @* begin
      rerr_nxt = 1'b0;
      case (paddr_in)
         `SFGS_OFS_BLEND: rdata_nxt = {16'h0000, blend_r};
         `SFGS_OFS_SFF_SEL: rdata_nxt = {16'h0000, sff_sel_r};
         `SFGS_OFS_SFF_GAIN: rdata_nxt = {16'h0000, sff_gain_r};
         `SFGS_OFS_SFF_FILT: rdata_nxt = {16'h0000, sff_filt_r};
         `SFGS_OFS_TFF_SEL: rdata_nxt = {16'h0000, tff_sel_r};
         `SFGS_OFS_TFF_GAIN: rdata_nxt = {16'h0000, tff_gain_r};
         `SFGS_OFS_TFF_FILT: rdata_nxt = {16'h0000, tff_filt_r};
         `SFGS_OFS_ROLE: rdata_nxt = {16'h0000, role_r};
         `SFGS_OFS_MODE: rdata_nxt = {16'h0000, mode_r};
         `SFGS_OFS_DELAY: rdata_nxt = {16'h0000, delay_r};
         `SFGS_OFS_LEVEL: rdata_nxt = {16'h0000, level_r};
         `SFGS_OFS_HYST: rdata_nxt = {16'h0000, hyst_r};
         `SFGS_OFS_RAMP: rdata_nxt = {16'h0000, ramp_r};
         // live state of the selector
         `SFGS_OFS_STATUS: rdata_nxt = {29'h00000000, ramping_r, p_only_out, group_r};
         default: begin
            rdata_nxt = 32'h00000000;
            rerr_nxt = 1'b1;
         end
      endcase
      // status is read-only
      if (pwrite_in && (paddr_in == `SFGS_OFS_STATUS)) begin
         rerr_nxt = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // apb response
   // ----------------------------------------------------------------
   // pready and data registered in setup, so access completes in one cycle
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         prdata_out <= 32'h00000000;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         pready_out <= psel_in & ~penable_in;
         pslverr_out <= psel_in & ~penable_in & rerr_nxt;
         if (psel_in && !penable_in && !pwrite_in) begin
            prdata_out <= rdata_nxt;
         end
      end
   end

   // ----------------------------------------------------------------
   // restart-effective latch
   // ----------------------------------------------------------------
   // select settings copied on each of the first three cycles after reset release
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         boot_r <= 2'b00;
         speed_ff_select_out <= 1'b0;
         torque_ff_select_out <= 2'b00;
      end else if (boot_r != 2'b11) begin
         boot_r <= boot_r + 2'b01;
         speed_ff_select_out <= sff_sel_r[0];
         torque_ff_select_out <= tff_sel_r[1:0];
      end
   end

   // ----------------------------------------------------------------
   // immediate settings to the loops
   // ----------------------------------------------------------------
   // immediate settings follow next cycle
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         speed_regulator_blend_out <= `SFGS_RST_BLEND;
         speed_ff_gain_out <= `SFGS_RST_SFF_GAIN;
         speed_ff_filter_time_out <= `SFGS_RST_SFF_FILT;
         torque_ff_gain_out <= `SFGS_RST_TFF_GAIN;
         torque_ff_filter_time_out <= `SFGS_RST_TFF_FILT;
      end else begin
         speed_regulator_blend_out <= blend_r;
         speed_ff_gain_out <= sff_gain_r;
         speed_ff_filter_time_out <= sff_filt_r;
         torque_ff_gain_out <= tff_gain_r;
         torque_ff_filter_time_out <= tff_filt_r;
      end
   end

   // ----------------------------------------------------------------
   // 0.1 ms tick prescaler
   // ----------------------------------------------------------------
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tick_r <= 16'h0000;
      end else if (tick_w) begin
         tick_r <= 16'h0000;
      end else begin
         tick_r <= tick_r + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // gain group decision
   // ----------------------------------------------------------------
   // decision evaluated every cycle
   always @* begin
      group_nxt = group_r;
      dly_cnt_nxt = 16'h0000;
      go_up_nxt = 1'b0;
      go_back_nxt = 1'b0;
      case (mode_r)
         16'h0000: group_nxt = 1'b0;
         16'h0001: group_nxt = 1'b1;
         // discrete input; role 0 keeps group one
         16'h0002: group_nxt = role_r[0] & di_sync_r;
         16'h0003, 16'h0005, 16'h0006, 16'h0009: begin
            go_up_nxt = (mag_w > up_th_w);
            go_back_nxt = (mag_w < dn_th_w);
         end
         16'h0007: begin
            go_up_nxt = !cmd_zero_w;
            go_back_nxt = cmd_zero_w;
         end
         16'h0008: begin
            go_up_nxt = !positioning_done_in;
            go_back_nxt = positioning_done_in;
         end
         // command plus low actual speed, no delay
         16'h000a: group_nxt = !cmd_zero_w | (group_r & (abs32(speed_fb_in) >= dn_th_w));
         // mode 4 and others hold group one
         default: group_nxt = 1'b0;
      endcase
      // shared return delay, restarts when the return condition drops
      if (go_up_nxt) begin
         group_nxt = 1'b1;
      end else if (group_r && go_back_nxt) begin
         if (dly_cnt_r >= delay_r) begin
            group_nxt = 1'b0;
         end else if (tick_w) begin
            dly_cnt_nxt = dly_cnt_r + 16'h0001;
         end else begin
            dly_cnt_nxt = dly_cnt_r;
         end
      end
   end

   // ----------------------------------------------------------------
   // upward ramp tracking
   // ----------------------------------------------------------------
   // ramp only on group one to two
   always @* begin
      ramping_nxt = ramping_r;
      ramp_cnt_nxt = ramp_cnt_r;
      if (!group_r && group_nxt) begin
         ramping_nxt = (ramp_r != 16'h0000);
         ramp_cnt_nxt = 16'h0000;
      end else if (!group_nxt) begin
         ramping_nxt = 1'b0;
         ramp_cnt_nxt = 16'h0000;
      end else if (ramping_r && tick_w) begin
         ramp_cnt_nxt = ramp_cnt_r + 16'h0001;
         if (ramp_cnt_nxt >= ramp_r) begin
            ramping_nxt = 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // selector state and loop-facing outputs
   // ----------------------------------------------------------------
   // one select bit covers all five mirrored gains
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         group_r <= 1'b0;
         dly_cnt_r <= 16'h0000;
         ramping_r <= 1'b0;
         ramp_cnt_r <= 16'h0000;
         gain_group_out <= 1'b0;
         p_only_out <= 1'b0;
         gain_blend_out <= 16'h0000;
         ramp_busy_out <= 1'b0;
      end else begin
         group_r <= group_nxt;
         dly_cnt_r <= dly_cnt_nxt;
         ramping_r <= ramping_nxt;
         ramp_cnt_r <= ramp_cnt_nxt;
         gain_group_out <= group_nxt;
         // role 0 makes the input a p/pi switch
         p_only_out <= (mode_r == 16'h0002) & ~role_r[0] & di_sync_r;
         ramp_busy_out <= ramping_nxt;
         // blend share of group two: ramp ticks 0 to ramp_r-1 while ramping, then 16'hffff
         if (!group_nxt) begin
            gain_blend_out <= 16'h0000;
         end else if (ramping_nxt) begin
            gain_blend_out <= ramp_cnt_nxt;
         end else begin
            gain_blend_out <= 16'hffff;
         end
      end
   end

endmodule // sfgs_gain_switch

// [tb/sfgs_loop_model.sv]
// model of the loop side: feeds one chosen loop signal, the rest stay zero
// assumes the bench steers it at the rising edge of clk_sys_in
`timescale 1ns/1ns
module sfgs_loop_model (
   input wire clk_sys_in,
   input wire [2:0] sel_in,
   input wire [31:0] mag_in,
   input wire done_in,
   output logic signed [31:0] torque_out,
   output logic signed [31:0] speed_cmd_out,
   output logic signed [31:0] deviation_out,
   output logic signed [31:0] pos_cmd_out,
   output logic signed [31:0] speed_fb_out,
   output logic done_out
);
   // registered like a real loop, so values change one edge late
   always @(posedge clk_sys_in) begin
      torque_out <= (sel_in == 3'h0) ? mag_in : 32'h0;
      speed_cmd_out <= (sel_in == 3'h1) ? mag_in : 32'h0;
      deviation_out <= (sel_in == 3'h2) ? mag_in : 32'h0;
      pos_cmd_out <= (sel_in == 3'h3) ? mag_in : 32'h0;
      speed_fb_out <= (sel_in == 3'h4) ? mag_in : 32'h0;
      done_out <= done_in;
   end
endmodule // sfgs_loop_model

// [tb/sfgs_gain_switch_assertions.sv]
// port checker of the gain switch selector
// assumes it is bound into sfgs_gain_switch
`timescale 1ns/1ns
module sfgs_gain_switch_checker (
   input wire clk_sys_in,
   input wire rst_b_in,
   input wire psel_in,
   input wire penable_in,
   input wire pready_out,
   input wire pslverr_out,
   input wire gain_group_out,
   input wire p_only_out,
   input wire ramp_busy_out,
   input wire [15:0] speed_regulator_blend_out,
   input wire speed_ff_select_out,
   input wire [15:0] speed_ff_gain_out,
   input wire [15:0] speed_ff_filter_time_out,
   input wire [1:0] torque_ff_select_out,
   input wire [15:0] torque_ff_gain_out,
   input wire [15:0] torque_ff_filter_time_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);
   // cycles since reset release, saturating
   logic [2:0] rel_r;
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) rel_r <= 3'h0;
      else if (rel_r != 3'h5) rel_r <= rel_r + 3'h1;
   end
   sequence s_setup;
      psel_in && !penable_in;
   endsequence
   a_ready_after_setup: assert property (s_setup |=> pready_out) else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready_out |=> !pready_out) else $error("ready held");
   a_err_with_ready: assert property (pslverr_out |-> pready_out) else $error("error without ready");
   a_blend_in_range: assert property (speed_regulator_blend_out <= 16'h03e8) else $error("blend high");
   a_sff_gain_range: assert property (speed_ff_gain_out <= 16'h05dc) else $error("sff gain high");
   a_filters_in_range: assert property (speed_ff_filter_time_out <= 16'h1900 &&
      torque_ff_filter_time_out <= 16'h1900) else $error("filter high");
   a_tff_in_range: assert property (torque_ff_gain_out <= 16'h03e8 && torque_ff_select_out != 2'h3)
      else $error("torque ff high");
   a_restart_sel_held: assert property (rel_r == 3'h5 |-> $stable(torque_ff_select_out) &&
      $stable(speed_ff_select_out)) else $error("restart setting moved");
   a_p_only_group1: assert property (p_only_out |-> !gain_group_out) else $error("p only in group two");
   a_ramp_up_only: assert property (ramp_busy_out |-> gain_group_out) else $error("ramp in group one");
endmodule // sfgs_gain_switch_checker
bind sfgs_gain_switch sfgs_gain_switch_checker u_chk (.clk_sys_in(clk_sys_in),
   .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .gain_group_out(gain_group_out), .p_only_out(p_only_out),
   .ramp_busy_out(ramp_busy_out), .speed_regulator_blend_out(speed_regulator_blend_out),
   .speed_ff_select_out(speed_ff_select_out), .speed_ff_gain_out(speed_ff_gain_out),
   .speed_ff_filter_time_out(speed_ff_filter_time_out), .torque_ff_select_out(torque_ff_select_out),
   .torque_ff_gain_out(torque_ff_gain_out), .torque_ff_filter_time_out(torque_ff_filter_time_out));

// [tb/test_servo_feedforward_gain_switch.sv]
// bench of the gain switch: apb master, loop model, per-scenario tasks
// assumes a 50 MHz clock and a 4-cycle tick for short delays
`timescale 1ns/1ns
`include "sfgs_regs.vh"
module test_servo_feedforward_gain_switch;
   logic clk_sys_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, din = 1'b0, done = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, mag = 32'h0, prdata, rd;
   logic [2:0] sel = 3'h0;
   logic pready, pslverr, err, grp, ponly, pdone, sffs, rbz;
   logic signed [31:0] tq, sc, pd, pc, sf;
   logic [1:0] tffs;
   logic [15:0] blend, sffg, sfft, tffg, tfft, gbl;
   int error_cnt = 0, tests_run = 0;
   always #10 clk_sys_in = ~clk_sys_in;
   sfgs_loop_model u_loop (.clk_sys_in(clk_sys_in), .sel_in(sel), .mag_in(mag), .done_in(done),
      .torque_out(tq), .speed_cmd_out(sc), .deviation_out(pd), .pos_cmd_out(pc), .speed_fb_out(sf), .done_out(pdone));
   sfgs_gain_switch #(.TICK_CYC(4)) dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .discrete_input_in(din), .torque_cmd_in(tq),
      .speed_cmd_in(sc), .pos_deviation_in(pd), .pos_cmd_in(pc), .speed_fb_in(sf), .positioning_done_in(pdone),
      .gain_group_out(grp), .p_only_out(ponly), .gain_blend_out(gbl), .ramp_busy_out(rbz),
      .speed_regulator_blend_out(blend), .speed_ff_select_out(sffs), .speed_ff_gain_out(sffg),
      .speed_ff_filter_time_out(sfft), .torque_ff_select_out(tffs), .torque_ff_gain_out(tffg),
      .torque_ff_filter_time_out(tfft));
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task cyc(input int n); repeat (n) @(posedge clk_sys_in); #1; endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s exp %h seen %h", nm, exp, got);
      end
   endtask
   // request held until pready is sampled high at an edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys_in);
      pen <= 1'b1;
      do @(posedge clk_sys_in); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; pen <= 1'b0;
   endtask
   task put(input logic [2:0] s, input logic [31:0] m, input logic d, input logic di);
      @(posedge clk_sys_in);
      sel <= s; mag <= m; done <= d; din <= di;
   endtask
   task set_mode(input logic [15:0] m); apb(1'b1, `SFGS_OFS_MODE, {16'h0, m}); cyc(40); endtask
   task close_out;
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_reset_vals;
      logic [15:0] rv [13] = '{16'h03e8, 0, 16'h012c, 16'h0032, 0, 0, 0, 0, 0, 16'h0032, 16'h0032, 16'h0021, 16'h0021};
      for (int i = 0; i < 13; i++) begin
         apb(1'b0, 12'(i * 4), 32'h0);
         chk("reset value", rd, {16'h0, rv[i]});
      end
      apb(1'b0, 12'h040, 32'h0);
      chk("unmapped error", err, 32'h1);
   endtask
   task t_clamp;
      logic [11:0] a [5] = '{`SFGS_OFS_BLEND, `SFGS_OFS_SFF_GAIN, `SFGS_OFS_SFF_FILT, `SFGS_OFS_TFF_GAIN, `SFGS_OFS_TFF_FILT};
      logic [15:0] e [5] = '{16'h03e8, 16'h05dc, 16'h1900, 16'h03e8, 16'h1900};
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, a[i], 32'hffff);
         apb(1'b0, a[i], 32'h0);
         chk("clamped", rd, {16'h0, e[i]});
      end
      apb(1'b1, `SFGS_OFS_SFF_GAIN, 32'h04d2);
      cyc(1);
      chk("gain now", sffg, 32'h04d2);
      apb(1'b1, `SFGS_OFS_TFF_SEL, 32'h2);
      apb(1'b1, `SFGS_OFS_SFF_SEL, 32'h1);
      cyc(3);
      chk("tff sel held", tffs, 32'h0);
      chk("sff sel held", sffs, 32'h0);
      apb(1'b0, `SFGS_OFS_TFF_SEL, 32'h0);
      chk("tff sel reg", rd, 32'h2);
   endtask
   task t_fixed_disc;
      set_mode(16'h1);
      chk("mode 1", grp, 32'h1);
      chk("ramp busy", rbz, 32'h1);
      cyc(140);
      chk("ramp done", gbl, 32'hffff);
      set_mode(16'h4);
      chk("mode 4", grp, 32'h0);
      chk("blend group one", gbl, 32'h0);
      apb(1'b1, `SFGS_OFS_ROLE, 32'h1);
      set_mode(16'h2);
      put(3'h0, 32'h0, 1'b1, 1'b1);
      cyc(6);
      chk("input group", grp, 32'h1);
      apb(1'b1, `SFGS_OFS_ROLE, 32'h0);
      cyc(40);
      chk("role 0 group", grp, 32'h0);
      chk("role 0 p only", ponly, 32'h1);
      put(3'h0, 32'h0, 1'b1, 1'b0);
      cyc(6);
      chk("pi again", ponly, 32'h0);
   endtask
   // boundaries 83 and 17 of level 50 and hysteresis 33, delay 4 ticks = 16 cycles
   task t_hyst;
      logic [15:0] md [4] = '{16'h3, 16'h5, 16'h6, 16'h9};
      logic [2:0] sl [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
      apb(1'b1, `SFGS_OFS_DELAY, 32'h4);
      for (int i = 0; i < 4; i++) begin
         put(sl[i], 32'd83, 1'b1, 1'b0);
         set_mode(md[i]);
         chk("at upper edge", grp, 32'h0);
         put(sl[i], -32'sd100, 1'b1, 1'b0);
         cyc(3);
         chk("switched up", grp, 32'h1);
         put(sl[i], 32'd16, 1'b1, 1'b0);
         cyc(10);
         put(sl[i], 32'd17, 1'b1, 1'b0);
         cyc(3);
         put(sl[i], 32'd16, 1'b1, 1'b0);
         cyc(10);
         chk("delay restarted", grp, 32'h1);
         cyc(20);
         chk("returned", grp, 32'h0);
      end
   endtask
   task step(input logic [15:0] m, input logic [2:0] s, input logic [31:0] v, input logic d, input logic hold);
      put(3'h0, 32'h0, 1'b1, 1'b0);
      set_mode(m);
      put(s, v, d, 1'b0);
      cyc(4);
      chk("command up", grp, 32'h1);
      put(s, 32'h0, 1'b1, 1'b0);
      cyc(6);
      chk("hold", grp, {31'h0, hold});
      cyc(30);
      chk("command down", grp, 32'h0);
   endtask
   initial begin
      repeat (16) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      cyc(1);
      t_reset_vals();
      t_clamp();
      t_fixed_disc();
      t_hyst();
      step(16'h7, 3'h3, 32'h5, 1'b1, 1'b1);
      step(16'h8, 3'h0, 32'h0, 1'b0, 1'b1);
      step(16'ha, 3'h3, 32'h5, 1'b1, 1'b0);
      close_out();
   end
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      error_cnt++;
      close_out();
   end
endmodule // test_servo_feedforward_gain_switch
